// file: verilog/aisel_pkg.sv
package aisel_pkg;

	// Register map
	localparam logic [7:0] ADDR_ANALOG_INPUT_SELECT_CTRL = 8'h02;
	localparam logic [7:0] RESET_ANALOG_INPUT_SELECT_CTRL = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// Field positions inside the control register
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 5;
	localparam int FUNC_LSB = 6;
	localparam int FUNC_MSB = 7;

	// Front end function select codes
	localparam logic [1:0] FUNC_BYPASS_A = 2'h0;
	localparam logic [1:0] FUNC_BYPASS_B = 2'h1;
	localparam logic [1:0] FUNC_AMP_ONLY = 2'h2;
	localparam logic [1:0] FUNC_AMP_AAF  = 2'h3;

	// Composite codes
	localparam logic [5:0] MODE_CVBS_1_3 = 6'h0E;
	localparam logic [5:0] MODE_CVBS_1_4 = 6'h0F;
	localparam logic [5:0] MODE_CVBS_3_1 = 6'h10;
	localparam logic [5:0] MODE_CVBS_3_2 = 6'h11;
	localparam logic [5:0] MODE_CVBS_4_1 = 6'h12;
	localparam logic [5:0] MODE_CVBS_4_2 = 6'h13;
	localparam logic [5:0] MODE_CVBS_4_3 = 6'h14;
	localparam logic [5:0] MODE_CVBS_4_4 = 6'h15;
	localparam logic [5:0] MODE_CVBS_3_3 = 6'h1E;
	localparam logic [5:0] MODE_CVBS_3_4 = 6'h1F;

	// Luma/chroma codes
	localparam logic [5:0] MODE_YC_PROG_1  = 6'h16;
	localparam logic [5:0] MODE_YC_PROG_2  = 6'h17;
	localparam logic [5:0] MODE_YC_TRACK_1 = 6'h18;
	localparam logic [5:0] MODE_YC_TRACK_2 = 6'h19;
	localparam logic [5:0] MODE_YC_PROG_3  = 6'h1A;
	localparam logic [5:0] MODE_YC_PROG_4  = 6'h1B;
	localparam logic [5:0] MODE_YC_TRACK_3 = 6'h1C;
	localparam logic [5:0] MODE_YC_TRACK_4 = 6'h1D;

	// Component colour-difference and sync-on-RGB codes
	localparam logic [5:0] MODE_YPBPR_1 = 6'h20;
	localparam logic [5:0] MODE_YPBPR_2 = 6'h21;
	localparam logic [5:0] MODE_YPBPR_3 = 6'h2E;
	localparam logic [5:0] MODE_YPBPR_4 = 6'h2F;
	localparam logic [5:0] MODE_RGB_1   = 6'h30;
	localparam logic [5:0] MODE_RGB_2   = 6'h31;
	localparam logic [5:0] MODE_RGB_3   = 6'h3E;
	localparam logic [5:0] MODE_RGB_4   = 6'h3F;

	// Converter channel masks and input columns
	localparam logic [3:0] CH_1    = 4'h1;
	localparam logic [3:0] CH_3    = 4'h4;
	localparam logic [3:0] CH_4    = 4'h8;
	localparam logic [3:0] CH_3_4  = 4'hC;
	localparam logic [3:0] CH_ALL  = 4'hF;
	localparam logic [3:0] CH_NONE = 4'h0;
	localparam logic [1:0] COL_1 = 2'h0;
	localparam logic [1:0] COL_2 = 2'h1;
	localparam logic [1:0] COL_3 = 2'h2;
	localparam logic [1:0] COL_4 = 2'h3;

	typedef enum {
		CLASS_NONE,
		CLASS_CVBS,
		CLASS_YC,
		CLASS_YPBPR,
		CLASS_RGB
	} mode_class_t;

	// Decoded input configuration
	typedef struct packed {
		logic [3:0] channel_on;
		logic [1:0] column;
		logic [3:0] agc_on;
		logic       chroma_gain_prog;
		logic       chroma_gain_track;
		logic       reserved_code;
		logic       unsupported_code;
	} route_t;

	// Front end controls
	typedef struct packed {
		logic amp_enable;
		logic aaf_enable;
	} front_end_t;

endpackage : aisel_pkg

// file: verilog/analog_input_mode_decoder.sv
// Summary of operation
// RQ1: Mode field is bits 5..0 of control register at subaddress 02h; decode it.
// RQ2: Code 0E routes composite from input 1-3 on channel one with AGC.
// RQ3: Code 0F routes composite from input 1-4 with AGC.
// RQ4: Codes 10 and 11 take composite with AGC from inputs 3-1, 3-2.
// RQ5: Codes 12 to 15 take composite with AGC from inputs 4-1 to 4-4.
// RQ6: Codes 1E and 1F take composite with AGC from inputs 3-3, 3-4.
// RQ7: Codes 16, 17: luma 3-1/3-2 with AGC, chroma 4-1/4-2 programmable gain.
// RQ8: Codes 18, 19: luma 3-1/3-2, chroma 4-1/4-2 gain tracking luma gain.
// RQ9: Codes 1A, 1B: luma 3-3/3-4 with AGC, chroma 4-3/4-4 programmable gain.
// RQ10: Codes 1C, 1D: luma 3-3/3-4, chroma 4-3/4-4 tracking luma gain.
// RQ11: Code 20: colour-difference input on column 1, AGC on sync channel only.
// RQ12: Code 21: colour-difference input on column 2, AGC on sync channel only.
// RQ13: Code 2E: colour-difference input on column 3, AGC on sync channel only.
// RQ14: Codes 30, 31: sync-on-RGB on column 1 or 2, sync channel AGC.
// RQ15: Codes 3E, 3F: sync-on-RGB on column 3 or 4, sync channel AGC.
// RQ16: Host avoids reserved codes 22-2D and 32-3D; no input configuration then.
// RQ17: Colour-difference input on column 4 decodes from code 2F.
// RQ18: Bits 7..6: 00/01 bypass amp and filter, 10 amp only, 11 both.
// RQ19: Host should set luma bypass to one in luma/chroma modes.
`timescale 1ns/1ns

module analog_input_mode_decoder (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// Register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	output logic      [7:0]            reg_rdata,
	// Decoded input configuration
	output aisel_pkg::route_t          route,
	output aisel_pkg::mode_class_t     mode_class,
	output logic      [15:0]           analog_in_enable,
	// Front end controls
	output aisel_pkg::front_end_t      front_end
);

	logic                   [7:0] analog_input_select_ctrl;
	logic                   [5:0] mode_field;
	logic                   [1:0] front_end_function_select;
	aisel_pkg::route_t            next_route;
	aisel_pkg::mode_class_t       next_mode_class;
	aisel_pkg::front_end_t        next_front_end;
	logic                   [15:0] next_analog_in_enable;

	// Control register, written at its subaddress only
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			analog_input_select_ctrl <=
				aisel_pkg::RESET_ANALOG_INPUT_SELECT_CTRL;
		end else if (reg_wr &&
			reg_addr == aisel_pkg::ADDR_ANALOG_INPUT_SELECT_CTRL) begin
			analog_input_select_ctrl <= reg_wdata; // RQ1
		end
	end

	// Read back, registered; other subaddresses answer zero
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= aisel_pkg::READ_UNMAPPED;
		end else if (reg_addr ==
			aisel_pkg::ADDR_ANALOG_INPUT_SELECT_CTRL) begin
			reg_rdata <= analog_input_select_ctrl;
		end else begin
			reg_rdata <= aisel_pkg::READ_UNMAPPED;
		end
	end

	// Field split
	assign mode_field = analog_input_select_ctrl[aisel_pkg::MODE_MSB:
		aisel_pkg::MODE_LSB]; // RQ1
	assign front_end_function_select =
		analog_input_select_ctrl[aisel_pkg::FUNC_MSB:aisel_pkg::FUNC_LSB];

	// Front end decode; both low codes bypass
	always_comb begin
		next_front_end.amp_enable = 1'b0;
		next_front_end.aaf_enable = 1'b0;
		case (front_end_function_select)
			aisel_pkg::FUNC_AMP_ONLY: begin
				next_front_end.amp_enable = 1'b1; // RQ18
			end
			aisel_pkg::FUNC_AMP_AAF: begin
				next_front_end.amp_enable = 1'b1; // RQ18
				next_front_end.aaf_enable = 1'b1; // RQ18
			end
			default: begin
				next_front_end.amp_enable = 1'b0; // RQ18
				next_front_end.aaf_enable = 1'b0;
			end
		endcase
	end

	// Mode decode; codes 00-0D are not decoded, only flagged as unsupported here
	always_comb begin
		next_route = '0;
		next_mode_class = aisel_pkg::CLASS_NONE;
		case (mode_field)
			aisel_pkg::MODE_CVBS_1_3: begin
				next_route.channel_on = aisel_pkg::CH_1; // RQ2
				next_route.column = aisel_pkg::COL_3;
				next_route.agc_on = aisel_pkg::CH_1;
				next_mode_class = aisel_pkg::CLASS_CVBS;
			end
			aisel_pkg::MODE_CVBS_1_4: begin
				next_route.channel_on = aisel_pkg::CH_1; // RQ3
				next_route.column = aisel_pkg::COL_4;
				next_route.agc_on = aisel_pkg::CH_1;
				next_mode_class = aisel_pkg::CLASS_CVBS;
			end
			aisel_pkg::MODE_CVBS_3_1,
			aisel_pkg::MODE_CVBS_3_2: begin
				next_route.channel_on = aisel_pkg::CH_3; // RQ4
				next_route.column = mode_field[1:0];
				next_route.agc_on = aisel_pkg::CH_3;
				next_mode_class = aisel_pkg::CLASS_CVBS;
			end
			aisel_pkg::MODE_CVBS_4_1,
			aisel_pkg::MODE_CVBS_4_2,
			aisel_pkg::MODE_CVBS_4_3,
			aisel_pkg::MODE_CVBS_4_4: begin
				// Codes 12..15 step through columns 1..4
				next_route.channel_on = aisel_pkg::CH_4; // RQ5
				next_route.column = 2'(mode_field[1:0] - 2'h2);
				next_route.agc_on = aisel_pkg::CH_4;
				next_mode_class = aisel_pkg::CLASS_CVBS;
			end
			aisel_pkg::MODE_CVBS_3_3,
			aisel_pkg::MODE_CVBS_3_4: begin
				next_route.channel_on = aisel_pkg::CH_3; // RQ6
				next_route.column = mode_field[0] ? aisel_pkg::COL_4 :
					aisel_pkg::COL_3;
				next_route.agc_on = aisel_pkg::CH_3;
				next_mode_class = aisel_pkg::CLASS_CVBS;
			end
			aisel_pkg::MODE_YC_PROG_1,
			aisel_pkg::MODE_YC_PROG_2: begin
				next_route.channel_on = aisel_pkg::CH_3_4; // RQ7
				next_route.column = mode_field[0] ? aisel_pkg::COL_2 :
					aisel_pkg::COL_1;
				next_route.agc_on = aisel_pkg::CH_3;
				next_route.chroma_gain_prog = 1'b1; // RQ7
				next_mode_class = aisel_pkg::CLASS_YC;
			end
			aisel_pkg::MODE_YC_TRACK_1,
			aisel_pkg::MODE_YC_TRACK_2: begin
				next_route.channel_on = aisel_pkg::CH_3_4; // RQ8
				next_route.column = mode_field[0] ? aisel_pkg::COL_2 :
					aisel_pkg::COL_1;
				next_route.agc_on = aisel_pkg::CH_3;
				next_route.chroma_gain_track = 1'b1; // RQ8
				next_mode_class = aisel_pkg::CLASS_YC;
			end
			aisel_pkg::MODE_YC_PROG_3,
			aisel_pkg::MODE_YC_PROG_4: begin
				next_route.channel_on = aisel_pkg::CH_3_4; // RQ9
				next_route.column = mode_field[0] ? aisel_pkg::COL_4 :
					aisel_pkg::COL_3;
				next_route.agc_on = aisel_pkg::CH_3;
				next_route.chroma_gain_prog = 1'b1; // RQ9
				next_mode_class = aisel_pkg::CLASS_YC;
			end
			aisel_pkg::MODE_YC_TRACK_3,
			aisel_pkg::MODE_YC_TRACK_4: begin
				next_route.channel_on = aisel_pkg::CH_3_4; // RQ10
				next_route.column = mode_field[0] ? aisel_pkg::COL_4 :
					aisel_pkg::COL_3;
				next_route.agc_on = aisel_pkg::CH_3;
				next_route.chroma_gain_track = 1'b1; // RQ10
				next_mode_class = aisel_pkg::CLASS_YC;
			end
			aisel_pkg::MODE_YPBPR_1: begin
				next_route.channel_on = aisel_pkg::CH_ALL; // RQ11
				next_route.column = aisel_pkg::COL_1;
				next_route.agc_on = aisel_pkg::CH_1; // RQ11
				next_mode_class = aisel_pkg::CLASS_YPBPR;
			end
			aisel_pkg::MODE_YPBPR_2: begin
				next_route.channel_on = aisel_pkg::CH_ALL; // RQ12
				next_route.column = aisel_pkg::COL_2;
				next_route.agc_on = aisel_pkg::CH_1; // RQ12
				next_mode_class = aisel_pkg::CLASS_YPBPR;
			end
			aisel_pkg::MODE_YPBPR_3: begin
				next_route.channel_on = aisel_pkg::CH_ALL; // RQ13
				next_route.column = aisel_pkg::COL_3;
				next_route.agc_on = aisel_pkg::CH_1; // RQ13
				next_mode_class = aisel_pkg::CLASS_YPBPR;
			end
			aisel_pkg::MODE_YPBPR_4: begin
				next_route.channel_on = aisel_pkg::CH_ALL; // RQ17
				next_route.column = aisel_pkg::COL_4;
				next_route.agc_on = aisel_pkg::CH_1; // RQ17
				next_mode_class = aisel_pkg::CLASS_YPBPR;
			end
			aisel_pkg::MODE_RGB_1,
			aisel_pkg::MODE_RGB_2: begin
				next_route.channel_on = aisel_pkg::CH_ALL; // RQ14
				next_route.column = mode_field[0] ? aisel_pkg::COL_2 :
					aisel_pkg::COL_1;
				next_route.agc_on = aisel_pkg::CH_1; // RQ14
				next_mode_class = aisel_pkg::CLASS_RGB;
			end
			aisel_pkg::MODE_RGB_3,
			aisel_pkg::MODE_RGB_4: begin
				next_route.channel_on = aisel_pkg::CH_ALL; // RQ15
				next_route.column = mode_field[0] ? aisel_pkg::COL_4 :
					aisel_pkg::COL_3;
				next_route.agc_on = aisel_pkg::CH_1; // RQ15
				next_mode_class = aisel_pkg::CLASS_RGB;
			end
			default: begin
				// Reserved upper codes connect nothing, so no pin is loaded
				next_route.channel_on = aisel_pkg::CH_NONE; // RQ16
				if (mode_field[5]) begin
					next_route.reserved_code = 1'b1; // RQ16
				end else begin
					next_route.unsupported_code = 1'b1;
				end
			end
		endcase
	end

	// Pin enables: channel k may only reach pins of its own row
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_pin
			// Constant slice per row, so no two blocks share a driver
			assign next_analog_in_enable[ch*4 +: 4] =
				next_route.channel_on[ch] ?
				(4'h1 << next_route.column) : 4'h0;
		end
	endgenerate

	// Decoded outputs held in flops to keep switch controls glitch free
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			route <= '0;
			mode_class <= aisel_pkg::CLASS_NONE;
			analog_in_enable <= 16'h0000;
		end else begin
			route <= next_route;
			mode_class <= next_mode_class;
			analog_in_enable <= next_analog_in_enable;
		end
	end

	// Front end flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			front_end <= '0;
		end else begin
			front_end <= next_front_end;
		end
	end

endmodule : analog_input_mode_decoder

// file: bench/aisel_checker_sva.sv
`timescale 1ns/1ns

module aisel_checker (
	// Clock and reset
	input wire logic                   sys_clk,
	input wire logic                   rst_b,
	// Register port
	input wire logic [7:0]             reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_wr,
	input wire logic [7:0]             reg_rdata,
	// Decoded outputs
	input wire aisel_pkg::route_t      route,
	input var  aisel_pkg::mode_class_t mode_class,
	input wire logic [15:0]            analog_in_enable,
	input wire aisel_pkg::front_end_t  front_end
);
	logic [7:0] ctl;

	// Own copy of the control register, so a stuck design flop shows up
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ctl <= 8'h00;
		else if (reg_wr && reg_addr == 8'h02)
			ctl <= reg_wdata;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	AST_READBACK: assert property (reg_addr == 8'h02 |=>
		reg_rdata == $past(ctl))
		else $error("control register reads back wrong");
	AST_UNMAPPED: assert property (reg_addr != 8'h02 |=>
		reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_FRONT_END: assert property (front_end ==
		{$past(ctl[7]), $past(ctl[7]) & $past(ctl[6])})
		else $error("front end controls wrong");
	AST_RESERVED: assert property ($past(ctl[5]) &&
		$past(ctl[3:0]) >= 4'h2 && $past(ctl[3:0]) <= 4'hD |->
		route.reserved_code && analog_in_enable == 16'h0000 &&
		mode_class == aisel_pkg::CLASS_NONE)
		else $error("reserved code not refused");
	AST_CVBS_SINGLE: assert property (
		mode_class == aisel_pkg::CLASS_CVBS |->
		$onehot(analog_in_enable) && route.agc_on == route.channel_on)
		else $error("composite mode not a single pin");
	AST_YC_PAIR: assert property (
		mode_class == aisel_pkg::CLASS_YC |->
		$countones(analog_in_enable) == 2 &&
		route.agc_on == aisel_pkg::CH_3 &&
		route.chroma_gain_prog == $past(ctl[1]) &&
		route.chroma_gain_track == !$past(ctl[1]))
		else $error("luma/chroma pair wrong");
	AST_COMPONENT: assert property (
		mode_class inside {aisel_pkg::CLASS_YPBPR, aisel_pkg::CLASS_RGB} |->
		route.column == $past(ctl[1:0]) &&
		analog_in_enable == (16'h1111 << route.column) &&
		route.agc_on == aisel_pkg::CH_1)
		else $error("component column or sync gain wrong");
	AST_COL4: assert property ($past(ctl[5:0]) == 6'h2F |->
		mode_class == aisel_pkg::CLASS_YPBPR && analog_in_enable == 16'h8888)
		else $error("column four component mode wrong");
endmodule : aisel_checker

bind analog_input_mode_decoder aisel_checker i_aisel_checker (
	.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
	.route(route), .mode_class(mode_class),
	.analog_in_enable(analog_in_enable), .front_end(front_end));

// file: bench/video_source_bank.sv
`timescale 1ns/1ns

module video_source_bank (
	// Pin connections from the decoder
	input  wire logic [15:0] analog_in_enable,
	// Sources reaching the converters
	output logic      [4:0]  sources_connected
);
	// Every pin carries a live source; only the count is modelled
	assign sources_connected = 5'($countones(analog_in_enable));
endmodule : video_source_bank

// file: bench/analog_input_mode_decoder_test.sv
`timescale 1ns/1ns

module analog_input_mode_decoder_test;
	logic                   sys_clk;
	logic                   rst_b;
	logic [7:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic                   reg_wr;
	logic [7:0]             reg_rdata;
	aisel_pkg::route_t      route;
	aisel_pkg::mode_class_t mode_class;
	logic [15:0]            analog_in_enable;
	aisel_pkg::front_end_t  front_end;
	logic [4:0]             sources_connected;
	logic [7:0]             val;
	aisel_pkg::mode_class_t cls;
	int                     fail_count;
	int                     n_compared;
	// Rows: mode code beside the pins it must connect
	logic [5:0]  code_tab [26] = '{6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13,
		6'h14, 6'h15, 6'h1E, 6'h1F, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B,
		6'h1C, 6'h1D, 6'h20, 6'h21, 6'h2E, 6'h2F, 6'h30, 6'h31, 6'h3E, 6'h3F};
	logic [15:0] pins_tab [26] = '{16'h0004, 16'h0008, 16'h0100, 16'h0200,
		16'h1000, 16'h2000, 16'h4000, 16'h8000, 16'h0400, 16'h0800, 16'h1100,
		16'h2200, 16'h1100, 16'h2200, 16'h4400, 16'h8800, 16'h4400, 16'h8800,
		16'h1111, 16'h2222, 16'h4444, 16'h8888, 16'h1111, 16'h2222, 16'h4444,
		16'h8888};

	analog_input_mode_decoder i_analog_input_mode_decoder (.sys_clk(sys_clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rdata(reg_rdata), .route(route),
		.mode_class(mode_class), .analog_in_enable(analog_in_enable),
		.front_end(front_end));
	video_source_bank i_video_source_bank (
		.analog_in_enable(analog_in_enable),
		.sources_connected(sources_connected));

	// Free-running system clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task check(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : check

	// Outputs settle one edge after the write edge, so wait past it
	task write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge sys_clk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		@(negedge sys_clk);
	endtask : write_reg

	task give_verdict;
		$display("Checks made: %0d, mismatches: %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// Main sequence, all inputs driven on the falling edge
	initial begin
		rst_b = 1'b0;
		reg_addr = 8'h02;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		fail_count = 0;
		n_compared = 0;
		repeat (10) @(negedge sys_clk);
		check(reg_rdata === 8'h00 && route === '0, "reset values");
		rst_b = 1'b1;
		@(negedge sys_clk);
		check(route.unsupported_code === 1'b1, "code 00 flag");
		// Rows cycle the front end field through all four codes as well
		// Luma bypass sits in another register and is left to the host
		for (int i = 0; i < 26; i++) begin
			val = {2'(i), code_tab[i]};
			write_reg(8'h02, val);
			if (!code_tab[i][5])
				cls = i < 10 ? aisel_pkg::CLASS_CVBS : aisel_pkg::CLASS_YC;
			else
				cls = code_tab[i][4] ? aisel_pkg::CLASS_RGB : aisel_pkg::CLASS_YPBPR;
			check(analog_in_enable === pins_tab[i] && mode_class === cls &&
				sources_connected === 5'($countones(pins_tab[i])),
				"row decode");
			check(reg_rdata === val, "readback");
			check(front_end === {val[7], &val[7:6]}, "front end");
			if (i >= 10 && i < 18)
				check(route.chroma_gain_prog === code_tab[i][1] &&
					route.chroma_gain_track === !code_tab[i][1],
					"gain");
		end
		// Write elsewhere is ignored and reads as zero
		write_reg(8'h03, 8'hFF);
		check(reg_rdata === 8'h00 && analog_in_enable === 16'h8888, "unmapped");
		// Back-to-back writes, the first seen for exactly one cycle
		reg_addr = 8'h02;
		reg_wdata = 8'hCE;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wdata = 8'h15;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		check(analog_in_enable === 16'h0004 && front_end === 2'h3, "first");
		@(negedge sys_clk);
		check(analog_in_enable === 16'h8000 && front_end === 2'h0, "second");
		for (int j = 2; j < 14; j++) begin
			for (int k = 2; k < 4; k++) begin
				write_reg(8'h02, {2'h0, 2'(k), 4'(j)});
				check(route.reserved_code === 1'b1 && analog_in_enable === 16'h0000
					&& mode_class === aisel_pkg::CLASS_NONE, "reserved");
			end
		end
		write_reg(8'h02, 8'h05);
		check(route.unsupported_code === 1'b1 && analog_in_enable === '0, "old");
		// Reset again in mid-run
		rst_b = 1'b0;
		@(negedge sys_clk);
		check(reg_rdata === 8'h00 && analog_in_enable === '0, "second reset");
		rst_b = 1'b1;
		@(negedge sys_clk);
		check(route.unsupported_code === 1'b1 && front_end === 2'h0 &&
			mode_class === aisel_pkg::CLASS_NONE, "after reset");
		repeat (2) @(negedge sys_clk);
		give_verdict();
	end
endmodule : analog_input_mode_decoder_test
